// ---- mdd_move_dest_decoder.sv ----
// destination decoder of the register transfer instruction
`timescale 1ns/1ps
// Behaviour
// RULE_01 - null code discards write, no target
// RULE_02 - 0NNN low nibble selects peripheral module register
// RULE_03 - 1000 low nibble selects 8-bit system registers
// RULE_04 - accumulator by index, or live accumulator
// RULE_05 - 1011 low nibble writes a prefix register
// RULE_06 - push: increment stack pointer, store word
// RULE_07 - stack pointer, vector, loop counters written
// RULE_08 - frame store at base plus displacement
// RULE_09 - frame group registers written directly
// RULE_10 - data pointer store, step or load
// RULE_11 - second bank system control, clock, watchdog
// RULE_12 - second bank accumulators eight to fifteen
// RULE_13 - second bank writes general high byte
// RULE_14 - byte into word: zero or prefix upper
// RULE_15 - word into byte keeps low byte
// RULE_16 - prefix lasts only one following instruction
module mdd_move_dest_decoder (
	input wire logic CLK_SYS,
	input wire logic RESET_N,
	input wire mdd_pkg::mdd_instr_t INSTR,
	input wire mdd_pkg::mdd_ptrs_t PTRS,
	output mdd_pkg::mdd_wr_t DEST_WR,
	output mdd_pkg::mdd_mem_t MEM_WR,
	output mdd_pkg::mdd_ptr_t PTR_UPD,
	output logic PREFIX_ACTIVE
);
	logic pfx_act_r;
	logic pfx_act_nxt;
	logic [2:0] pfx_idx_r;
	logic [2:0] pfx_idx_nxt;
	logic [7:0] pfx_data;
	mdd_pkg::mdd_wr_t wr_r;
	mdd_pkg::mdd_wr_t wr_nxt;
	mdd_pkg::mdd_mem_t mem_r;
	mdd_pkg::mdd_mem_t mem_nxt;
	mdd_pkg::mdd_ptr_t ptr_r;
	mdd_pkg::mdd_ptr_t ptr_nxt;
	logic [2:0] hi;
	logic [3:0] lo;
	logic [1:0] bank;
	logic dst_wide;
	logic pfx_we;
	logic [15:0] wdata;
	logic [15:0] step;

	// pointer step of one, up or down
	function automatic logic [15:0] bump(input logic [15:0] v, input logic down);
		bump = down ? v - 16'h0001 : v + 16'h0001;
	endfunction

	// width conversion toward the destination
	function automatic logic [15:0] fit(input logic [15:0] src, input logic src_byte,
		input logic wide, input logic [7:0] upper);
		if (!wide) begin
			fit = {mdd_pkg::UPPER_ZERO, src[7:0]}; // RULE_15
		end else if (src_byte) begin
			fit = {upper, src[7:0]}; // RULE_14
		end else begin
			fit = src; // word into word passes unchanged
		end
	endfunction

	mdd_prefix_store #(
		.DEPTH(mdd_pkg::PREFIX_REG),
		.AW(mdd_pkg::PFX_AW),
		.DW(mdd_pkg::BYTE_W)
	) u_prefix (
		.clk(CLK_SYS),
		.reset_n(RESET_N),
		.we(pfx_we),
		.waddr(hi),
		.wdata(INSTR.src[7:0]),
		.raddr(pfx_idx_nxt),
		.rdata(pfx_data)
	);

	assign hi = INSTR.dst[6:4];
	assign lo = INSTR.dst[3:0];
	assign bank = pfx_act_r ? pfx_idx_r[2:1] : 2'h0;
	assign pfx_we = INSTR.valid && (lo == mdd_pkg::LO_PFX);

	always_comb begin
		pfx_act_nxt = pfx_act_r;
		pfx_idx_nxt = pfx_idx_r;
		if (INSTR.valid) begin
			pfx_act_nxt = pfx_we; // RULE_16
			if (pfx_we) begin
				pfx_idx_nxt = hi; // RULE_05
			end
		end
	end

	always_comb begin
		wr_nxt = '0;
		mem_nxt = '0;
		ptr_nxt = '0;
		wr_nxt.tgt = mdd_pkg::TGT_NONE;
		ptr_nxt.sel = mdd_pkg::PTR_SP;
		dst_wide = !INSTR.src_byte;
		step = 16'h0000;
		if (INSTR.valid) begin
			wr_nxt.we = 1'b1;
			if (INSTR.dst == mdd_pkg::CODE_NULL) begin
				wr_nxt.we = 1'b0; // RULE_01
				wr_nxt.discard = 1'b1; // RULE_01
			end else if (!lo[3]) begin
				wr_nxt.tgt = mdd_pkg::TGT_MODULE; // RULE_02
				wr_nxt.idx = {bank, hi}; // RULE_02
				if (lo[2:0] > mdd_pkg::MOD_MAX) begin
					wr_nxt.we = 1'b0;
					wr_nxt.bad = 1'b1;
					wr_nxt.tgt = mdd_pkg::TGT_NONE;
				end
			end else begin
				case (lo)
					mdd_pkg::LO_SYS: begin
						dst_wide = 1'b0;
						if (bank[0]) begin
							case (hi) // RULE_11
								mdd_pkg::SYS2_SC: wr_nxt.tgt = mdd_pkg::TGT_SYS_CTRL;
								mdd_pkg::SYS2_CK: wr_nxt.tgt = mdd_pkg::TGT_CLK_CTRL;
								mdd_pkg::SYS2_WD: wr_nxt.tgt = mdd_pkg::TGT_WDOG_CTRL;
								default: wr_nxt.tgt = mdd_pkg::TGT_NONE;
							endcase
						end else begin
							case (hi) // RULE_03
								mdd_pkg::SYS_AP: wr_nxt.tgt = mdd_pkg::TGT_SUM_PTR;
								mdd_pkg::SYS_APC: wr_nxt.tgt = mdd_pkg::TGT_SUM_PTR_CTRL;
								mdd_pkg::SYS_PSF: wr_nxt.tgt = mdd_pkg::TGT_STATUS;
								mdd_pkg::SYS_IC: wr_nxt.tgt = mdd_pkg::TGT_INT_CTRL;
								mdd_pkg::SYS_IMR: wr_nxt.tgt = mdd_pkg::TGT_INT_MASK;
								default: wr_nxt.tgt = mdd_pkg::TGT_NONE;
							endcase
						end
					end
					mdd_pkg::LO_ACC: begin
						wr_nxt.tgt = mdd_pkg::TGT_SUM_REG; // RULE_04
						wr_nxt.idx = {1'b0, bank[0], hi}; // RULE_12
						if (bank[0]) begin
							dst_wide = 1'b1; // RULE_12
						end
					end
					mdd_pkg::LO_LIVE: begin
						if (hi == mdd_pkg::HI_LIVE) begin
							wr_nxt.tgt = mdd_pkg::TGT_SUM_REG; // RULE_04
							wr_nxt.idx = {1'b0, PTRS.ap}; // RULE_04
						end
					end
					mdd_pkg::LO_PFX: begin
						wr_nxt.tgt = mdd_pkg::TGT_PREFIX; // RULE_05
						wr_nxt.idx = {2'h0, hi};
						dst_wide = 1'b0;
					end
					mdd_pkg::LO_STK: begin
						dst_wide = 1'b1;
						if (hi == mdd_pkg::STK_PUSH) begin
							step = bump(PTRS.sp, 1'b0); // RULE_06
							wr_nxt.tgt = mdd_pkg::TGT_MEMORY;
							mem_nxt.we = 1'b1; // RULE_06
							mem_nxt.addr = step; // RULE_06
							ptr_nxt.we = 1'b1;
							ptr_nxt.sel = mdd_pkg::PTR_SP;
							ptr_nxt.value = step;
						end else if (hi == mdd_pkg::STK_SP) begin
							wr_nxt.tgt = mdd_pkg::TGT_STACK_PTR; // RULE_07
						end else if (hi == mdd_pkg::STK_IV) begin
							wr_nxt.tgt = mdd_pkg::TGT_INT_VECTOR; // RULE_07
						end else if (hi[2:1] == mdd_pkg::STK_LC) begin
							wr_nxt.tgt = mdd_pkg::TGT_LOOP_CNT; // RULE_07
							wr_nxt.idx = {4'h0, hi[0]};
						end
					end
					mdd_pkg::LO_FRM: begin
						if (bank[0]) begin
							if (hi == mdd_pkg::FRM2_GRH) begin
								wr_nxt.tgt = mdd_pkg::TGT_GEN_HIGH; // RULE_13
								dst_wide = 1'b0;
							end
						end else if (hi <= mdd_pkg::FRM_DEC) begin
							step = {8'h00, PTRS.frame_displacement}; // RULE_08
							if (hi != mdd_pkg::FRM_KEEP) begin
								step = {8'h00, 8'(bump({8'h00, PTRS.frame_displacement}, hi[1]))}; // RULE_08
								ptr_nxt.we = 1'b1;
								ptr_nxt.sel = mdd_pkg::PTR_FRAME_DISPLACEMENT;
								ptr_nxt.value = step;
							end
							wr_nxt.tgt = mdd_pkg::TGT_MEMORY;
							mem_nxt.we = 1'b1;
							mem_nxt.addr = PTRS.bp + step; // RULE_08
						end else begin
							case (hi) // RULE_09
								mdd_pkg::FRM_FRAME_DISPLACEMENT: begin
									wr_nxt.tgt = mdd_pkg::TGT_FRAME_DISP;
									dst_wide = 1'b0;
								end
								mdd_pkg::FRM_DPC: begin
									wr_nxt.tgt = mdd_pkg::TGT_DPTR_CTRL;
									dst_wide = 1'b1;
								end
								mdd_pkg::FRM_GR: begin
									wr_nxt.tgt = mdd_pkg::TGT_GEN;
									dst_wide = 1'b1;
								end
								mdd_pkg::FRM_GRL: begin
									wr_nxt.tgt = mdd_pkg::TGT_GEN_LOW;
									dst_wide = 1'b0;
								end
								mdd_pkg::FRM_BP: begin
									wr_nxt.tgt = mdd_pkg::TGT_BASE_PTR;
									dst_wide = 1'b1;
								end
								default: wr_nxt.tgt = mdd_pkg::TGT_NONE;
							endcase
						end
					end
					mdd_pkg::LO_DPTR: begin
						ptr_nxt.sel = hi[2] ? mdd_pkg::PTR_DP1 : mdd_pkg::PTR_DP0;
						step = hi[2] ? PTRS.dp1 : PTRS.dp0;
						if (hi[1:0] == mdd_pkg::DPM_SET) begin
							wr_nxt.tgt = mdd_pkg::TGT_DATA_PTR; // RULE_10
							wr_nxt.idx = {4'h0, hi[2]};
							dst_wide = 1'b1;
						end else begin
							if (hi[1:0] != mdd_pkg::DPM_KEEP) begin
								step = bump(step, hi[1:0] == mdd_pkg::DPM_DEC); // RULE_10
								ptr_nxt.we = 1'b1;
								ptr_nxt.value = step;
							end
							wr_nxt.tgt = mdd_pkg::TGT_MEMORY;
							mem_nxt.we = 1'b1;
							mem_nxt.addr = step; // RULE_10
						end
					end
					default: wr_nxt.tgt = mdd_pkg::TGT_NONE;
				endcase
				if (wr_nxt.tgt == mdd_pkg::TGT_NONE) begin
					wr_nxt.we = 1'b0;
					wr_nxt.bad = 1'b1;
				end
			end
			wdata = fit(INSTR.src, INSTR.src_byte, dst_wide,
				pfx_act_r ? pfx_data : mdd_pkg::UPPER_ZERO); // RULE_14
			wr_nxt.wide = dst_wide;
			wr_nxt.data = wr_nxt.we ? wdata : 16'h0000;
			mem_nxt.wide = dst_wide;
			mem_nxt.data = mem_nxt.we ? wdata : 16'h0000;
		end else begin
			wdata = 16'h0000;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			pfx_act_r <= 1'b0;
			pfx_idx_r <= mdd_pkg::PFX_IDX_RST;
			wr_r <= '0;
			mem_r <= '0;
			ptr_r <= '0;
		end else begin
			pfx_act_r <= pfx_act_nxt;
			pfx_idx_r <= pfx_idx_nxt;
			wr_r <= wr_nxt;
			mem_r <= mem_nxt;
			ptr_r <= ptr_nxt;
		end
	end

	assign DEST_WR = wr_r;
	assign MEM_WR = mem_r;
	assign PTR_UPD = ptr_r;
	assign PREFIX_ACTIVE = pfx_act_r;
endmodule

// ---- mdd_pkg.sv ----
// constants and carrier types of the move destination decoder
package mdd_pkg;
	localparam int DST_W = 7;
	localparam int DATA_W = 16;
	localparam int BYTE_W = 8;
	localparam int PREFIX_REG = 8;
	localparam int PFX_AW = 3;
	localparam int IDX_W = 5;
	localparam logic [6:0] CODE_NULL = 7'h76;
	localparam logic [3:0] LO_SYS = 4'h8;
	localparam logic [3:0] LO_ACC = 4'h9;
	localparam logic [3:0] LO_LIVE = 4'hA;
	localparam logic [3:0] LO_PFX = 4'hB;
	localparam logic [3:0] LO_STK = 4'hD;
	localparam logic [3:0] LO_FRM = 4'hE;
	localparam logic [3:0] LO_DPTR = 4'hF;
	localparam logic [2:0] MOD_MAX = 3'h5;
	localparam logic [2:0] HI_LIVE = 3'h0;
	localparam logic [2:0] SYS_AP = 3'h0;
	localparam logic [2:0] SYS_APC = 3'h1;
	localparam logic [2:0] SYS_PSF = 3'h4;
	localparam logic [2:0] SYS_IC = 3'h5;
	localparam logic [2:0] SYS_IMR = 3'h6;
	localparam logic [2:0] SYS2_SC = 3'h0;
	localparam logic [2:0] SYS2_CK = 3'h6;
	localparam logic [2:0] SYS2_WD = 3'h7;
	localparam logic [2:0] STK_PUSH = 3'h0;
	localparam logic [2:0] STK_SP = 3'h1;
	localparam logic [2:0] STK_IV = 3'h2;
	localparam logic [1:0] STK_LC = 2'h3;
	localparam logic [2:0] FRM_KEEP = 3'h0;
	localparam logic [2:0] FRM_INC = 3'h1;
	localparam logic [2:0] FRM_DEC = 3'h2;
	localparam logic [2:0] FRM_FRAME_DISPLACEMENT = 3'h3;
	localparam logic [2:0] FRM_DPC = 3'h4;
	localparam logic [2:0] FRM_GR = 3'h5;
	localparam logic [2:0] FRM_GRL = 3'h6;
	localparam logic [2:0] FRM_BP = 3'h7;
	localparam logic [2:0] FRM2_GRH = 3'h1;
	localparam logic [1:0] DPM_KEEP = 2'h0;
	localparam logic [1:0] DPM_INC = 2'h1;
	localparam logic [1:0] DPM_DEC = 2'h2;
	localparam logic [1:0] DPM_SET = 2'h3;
	localparam logic [7:0] UPPER_ZERO = 8'h00;
	localparam logic [2:0] PFX_IDX_RST = 3'h0;

	typedef enum logic [4:0] {
		TGT_NONE = 5'h00,
		TGT_MODULE = 5'h01,
		TGT_SUM_PTR = 5'h02,
		TGT_SUM_PTR_CTRL = 5'h03,
		TGT_STATUS = 5'h04,
		TGT_INT_CTRL = 5'h05,
		TGT_INT_MASK = 5'h06,
		TGT_SYS_CTRL = 5'h07,
		TGT_CLK_CTRL = 5'h08,
		TGT_WDOG_CTRL = 5'h09,
		TGT_SUM_REG = 5'h0A,
		TGT_PREFIX = 5'h0B,
		TGT_STACK_PTR = 5'h0C,
		TGT_INT_VECTOR = 5'h0D,
		TGT_LOOP_CNT = 5'h0E,
		TGT_FRAME_DISP = 5'h0F,
		TGT_DPTR_CTRL = 5'h10,
		TGT_GEN = 5'h11,
		TGT_GEN_LOW = 5'h12,
		TGT_GEN_HIGH = 5'h13,
		TGT_BASE_PTR = 5'h14,
		TGT_DATA_PTR = 5'h15,
		TGT_MEMORY = 5'h16
	} mdd_target_t;

	typedef enum logic [1:0] {
		PTR_SP = 2'h0,
		PTR_FRAME_DISPLACEMENT = 2'h1,
		PTR_DP0 = 2'h2,
		PTR_DP1 = 2'h3
	} mdd_ptr_sel_t;

	typedef struct packed {
		logic valid;
		logic [6:0] dst;
		logic [15:0] src;
		logic src_byte;
	} mdd_instr_t;

	typedef struct packed {
		logic [15:0] sp;
		logic [15:0] bp;
		logic [7:0] frame_displacement;
		logic [15:0] dp0;
		logic [15:0] dp1;
		logic [3:0] ap;
	} mdd_ptrs_t;

	typedef struct packed {
		logic we;
		logic discard;
		logic bad;
		mdd_target_t tgt;
		logic [4:0] idx;
		logic wide;
		logic [15:0] data;
	} mdd_wr_t;

	typedef struct packed {
		logic we;
		logic wide;
		logic [15:0] addr;
		logic [15:0] data;
	} mdd_mem_t;

	typedef struct packed {
		logic we;
		mdd_ptr_sel_t sel;
		logic [15:0] value;
	} mdd_ptr_t;
endpackage

// ---- mdd_prefix_store.sv ----
// eight-entry prefix byte store with registered, write-through read
`timescale 1ns/1ps
module mdd_prefix_store #(
	parameter int DEPTH = 8,
	parameter int AW = 3,
	parameter int DW = 8
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata
);
	logic [DW-1:0] mem [DEPTH];
	logic [DW-1:0] rdata_nxt;

	// write-through so the very next instruction sees a fresh prefix
	always_comb begin
		rdata_nxt = mem[raddr];
		if (we && (waddr == raddr)) begin
			rdata_nxt = wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata <= '0;
		end else begin
			rdata <= rdata_nxt;
		end
	end
endmodule

// ---- mdd_checker_props.sv ----
// assertion checker of the move destination decoder
`timescale 1ns/1ps
module mdd_checker (
	input wire logic CLK_SYS,
	input wire logic RESET_N,
	input wire mdd_pkg::mdd_instr_t INSTR,
	input wire mdd_pkg::mdd_ptrs_t PTRS,
	input wire mdd_pkg::mdd_wr_t DEST_WR,
	input wire mdd_pkg::mdd_mem_t MEM_WR,
	input wire mdd_pkg::mdd_ptr_t PTR_UPD,
	input wire logic PREFIX_ACTIVE
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RESET_N);
	logic go;
	logic [6:0] d;
	assign go = INSTR.valid;
	assign d = INSTR.dst;
	null_discard_a: assert property (
		go && d == mdd_pkg::CODE_NULL |=> DEST_WR.discard && !DEST_WR.we && !PTR_UPD.we)
		else $error("null code not discarded");
	module_bad_a: assert property (
		go && d != mdd_pkg::CODE_NULL && !d[3] && d[2:0] > mdd_pkg::MOD_MAX
		|=> DEST_WR.bad && !DEST_WR.we)
		else $error("missing module accepted");
	push_addr_a: assert property (
		go && d == 7'h0D |=> MEM_WR.we && MEM_WR.wide && MEM_WR.addr == $past(PTRS.sp) + 16'h1)
		else $error("push address wrong");
	frame_addr_a: assert property (
		go && d == 7'h0E |=> MEM_WR.we && MEM_WR.addr == $past(PTRS.bp) + {8'h00, $past(PTRS.frame_displacement)})
		else $error("frame address wrong");
	dptr_step_a: assert property (
		go && d == 7'h5F |=> PTR_UPD.we && PTR_UPD.sel == mdd_pkg::PTR_DP1
		&& PTR_UPD.value == $past(PTRS.dp1) + 16'h1)
		else $error("pointer step wrong");
	prefix_set_a: assert property (
		go && d[3:0] == mdd_pkg::LO_PFX |=> PREFIX_ACTIVE && DEST_WR.tgt == mdd_pkg::TGT_PREFIX)
		else $error("prefix not taken");
	prefix_once_a: assert property (
		PREFIX_ACTIVE && go && d[3:0] != mdd_pkg::LO_PFX |=> !PREFIX_ACTIVE)
		else $error("prefix outlived its instruction");
	narrow_low_a: assert property (
		DEST_WR.we && !DEST_WR.wide && DEST_WR.tgt != mdd_pkg::TGT_MEMORY
		|-> DEST_WR.data[15:8] == 8'h00)
		else $error("byte write carries upper bits");
	byte_zero_a: assert property (
		go && INSTR.src_byte && !PREFIX_ACTIVE |=> DEST_WR.data[15:8] == 8'h00)
		else $error("byte source upper not zero");
	cover property (go && d == 7'h0D);
	cover property (PREFIX_ACTIVE && go);
	cover property (go && d == 7'h1E);
endmodule
bind mdd_move_dest_decoder mdd_checker u_mdd_checker (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
	.INSTR(INSTR), .PTRS(PTRS), .DEST_WR(DEST_WR), .MEM_WR(MEM_WR), .PTR_UPD(PTR_UPD),
	.PREFIX_ACTIVE(PREFIX_ACTIVE));

// ---- mdd_regfile_model.sv ----
// register file pointers and data memory facing the decoder
`timescale 1ns/1ps
module mdd_regfile_model (
	input wire logic clk,
	input wire logic reset_n,
	input wire mdd_pkg::mdd_mem_t mem_wr,
	input wire mdd_pkg::mdd_ptr_t ptr_upd,
	output mdd_pkg::mdd_ptrs_t ptrs
);
	logic [15:0] mem [65536];
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ptrs <= '{16'h0100, 16'h2000, 8'hFF, 16'h3000, 16'h4000, 4'h3};
		end else if (ptr_upd.we) begin
			case (ptr_upd.sel)
				mdd_pkg::PTR_SP: ptrs.sp <= ptr_upd.value;
				mdd_pkg::PTR_FRAME_DISPLACEMENT: ptrs.frame_displacement <= ptr_upd.value[7:0];
				mdd_pkg::PTR_DP0: ptrs.dp0 <= ptr_upd.value;
				default: ptrs.dp1 <= ptr_upd.value;
			endcase
		end
	end
	always_ff @(posedge clk) begin
		if (mem_wr.we) begin
			mem[mem_wr.addr] <= mem_wr.data;
		end
	end
endmodule

// ---- tb.sv ----
// self-checking bench of the move destination decoder
`timescale 1ns/1ps
module tb;
	logic CLK_SYS = 1'h0;
	logic RESET_N = 1'h0;
	mdd_pkg::mdd_instr_t INSTR = '0;
	mdd_pkg::mdd_ptrs_t PTRS;
	mdd_pkg::mdd_wr_t DEST_WR;
	mdd_pkg::mdd_mem_t MEM_WR;
	mdd_pkg::mdd_ptr_t PTR_UPD;
	logic PREFIX_ACTIVE;
	int fail_count = 0;
	int n_tests = 0;
	mdd_move_dest_decoder u_mdd_move_dest_decoder (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
		.INSTR(INSTR), .PTRS(PTRS), .DEST_WR(DEST_WR), .MEM_WR(MEM_WR), .PTR_UPD(PTR_UPD),
		.PREFIX_ACTIVE(PREFIX_ACTIVE));
	mdd_regfile_model u_mdd_regfile_model (.clk(CLK_SYS), .reset_n(RESET_N), .mem_wr(MEM_WR),
		.ptr_upd(PTR_UPD), .ptrs(PTRS));
	initial forever #10 CLK_SYS = ~CLK_SYS;
	task automatic chk(logic [47:0] seen, logic [47:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic op(logic [6:0] d, logic [15:0] s, logic b);
		@(negedge CLK_SYS);
		INSTR = '{1'h1, d, s, b};
	endtask
	task automatic done();
		@(negedge CLK_SYS);
		INSTR.valid = 1'h0;
	endtask
	task automatic ex(mdd_pkg::mdd_target_t t, logic [15:0] d, logic w);
		chk({DEST_WR.we, DEST_WR.tgt, DEST_WR.wide, DEST_WR.data}, {1'h1, t, w, d});
	endtask
	task automatic one(logic [6:0] d, logic [15:0] s, logic b, mdd_pkg::mdd_target_t t, logic w);
		op(d, s, b);
		done();
		ex(t, (w && !b) ? s : {8'h00, s[7:0]}, w);
	endtask
	task automatic mem(logic [6:0] d, logic [15:0] a);
		op(d, 16'h5A5A, 1'h0);
		done();
		chk({MEM_WR.we, MEM_WR.wide, MEM_WR.addr, MEM_WR.data}, {2'h3, a, 16'h5A5A});
	endtask
	task automatic pb(logic [6:0] d, mdd_pkg::mdd_target_t t);
		op(7'h2B, 16'h0000, 1'h1);
		op(d, 16'hCAFE, 1'h0);
		done();
		ex(t, 16'h00FE, 1'h0);
	endtask
	task automatic t_null();
		op(mdd_pkg::CODE_NULL, 16'hABCD, 1'h0);
		done();
		chk({DEST_WR.we, DEST_WR.discard, PTR_UPD.we}, 3'h2);
	endtask
	task automatic t_module();
		for (int m = 0; m < 8; m++) begin
			op({3'h2, 1'h0, 3'(m)}, 16'h1234, 1'h0);
			done();
			if (m < 6) chk({DEST_WR.we, DEST_WR.tgt, DEST_WR.idx}, {1'h1, mdd_pkg::TGT_MODULE, 5'h02});
			else chk({DEST_WR.we, DEST_WR.bad}, 2'h1);
		end
	endtask
	task automatic t_core();
		one(7'h08, 16'hBEEF, 1'h0, mdd_pkg::TGT_SUM_PTR, 1'h0);
		one(7'h18, 16'hBEEF, 1'h0, mdd_pkg::TGT_SUM_PTR_CTRL, 1'h0);
		one(7'h48, 16'hBEEF, 1'h0, mdd_pkg::TGT_STATUS, 1'h0);
		one(7'h58, 16'hBEEF, 1'h0, mdd_pkg::TGT_INT_CTRL, 1'h0);
		one(7'h68, 16'hBEEF, 1'h0, mdd_pkg::TGT_INT_MASK, 1'h0);
		one(7'h79, 16'h1234, 1'h0, mdd_pkg::TGT_SUM_REG, 1'h1);
		chk(DEST_WR.idx, 5'h07);
		one(7'h0A, 16'hFF55, 1'h1, mdd_pkg::TGT_SUM_REG, 1'h0);
		chk(DEST_WR.idx, {1'h0, PTRS.ap});
	endtask
	task automatic t_mem();
		mem(7'h0D, 16'h0101);
		chk({PTR_UPD.we, PTR_UPD.sel, PTR_UPD.value}, {1'h1, mdd_pkg::PTR_SP, 16'h0101});
		mem(7'h0E, 16'h20FF);
		mem(7'h1E, 16'h2000);
		chk({PTR_UPD.we, PTR_UPD.sel, PTR_UPD.value}, {1'h1, mdd_pkg::PTR_FRAME_DISPLACEMENT, 16'h0000});
		mem(7'h2E, 16'h20FF);
		mem(7'h4F, 16'h4000);
		chk(PTR_UPD.we, 1'h0);
		mem(7'h5F, 16'h4001);
		chk({PTR_UPD.we, PTR_UPD.sel, PTR_UPD.value}, {1'h1, mdd_pkg::PTR_DP1, 16'h4001});
		mem(7'h6F, 16'h4000);
		chk({PTRS.sp, u_mdd_regfile_model.mem[16'h0101]}, {16'h0101, 16'h5A5A});
	endtask
	task automatic t_regs();
		one(7'h1D, 16'h1234, 1'h0, mdd_pkg::TGT_STACK_PTR, 1'h1);
		one(7'h2D, 16'h1234, 1'h0, mdd_pkg::TGT_INT_VECTOR, 1'h1);
		one(7'h7D, 16'h1234, 1'h0, mdd_pkg::TGT_LOOP_CNT, 1'h1);
		chk(DEST_WR.idx, 5'h01);
		one(7'h3E, 16'h1234, 1'h0, mdd_pkg::TGT_FRAME_DISP, 1'h0);
		one(7'h4E, 16'h1234, 1'h0, mdd_pkg::TGT_DPTR_CTRL, 1'h1);
		one(7'h5E, 16'h1234, 1'h0, mdd_pkg::TGT_GEN, 1'h1);
		one(7'h6E, 16'h1234, 1'h0, mdd_pkg::TGT_GEN_LOW, 1'h0);
		one(7'h7E, 16'h1234, 1'h0, mdd_pkg::TGT_BASE_PTR, 1'h1);
		one(7'h7F, 16'h1234, 1'h0, mdd_pkg::TGT_DATA_PTR, 1'h1);
	endtask
	task automatic t_bank2();
		op(7'h2B, 16'h0030, 1'h1);
		op(7'h09, 16'h0040, 1'h1);
		chk({DEST_WR.tgt, DEST_WR.idx, PREFIX_ACTIVE}, {mdd_pkg::TGT_PREFIX, 5'h02, 1'h1});
		done();
		ex(mdd_pkg::TGT_SUM_REG, 16'h3040, 1'h1);
		chk({DEST_WR.idx, PREFIX_ACTIVE}, {5'h08, 1'h0});
		pb(7'h08, mdd_pkg::TGT_SYS_CTRL);
		pb(7'h68, mdd_pkg::TGT_CLK_CTRL);
		pb(7'h78, mdd_pkg::TGT_WDOG_CTRL);
		pb(7'h1E, mdd_pkg::TGT_GEN_HIGH);
		one(7'h09, 16'h0055, 1'h1, mdd_pkg::TGT_SUM_REG, 1'h0);
		chk(DEST_WR.idx, 5'h00);
		op(7'h0B, 16'h0001, 1'h1);
		op(7'h3F, 16'h0010, 1'h1);
		done();
		ex(mdd_pkg::TGT_DATA_PTR, 16'h0110, 1'h1);
	endtask
	task automatic t_reset();
		op(7'h2B, 16'h0012, 1'h1);
		done();
		chk(PREFIX_ACTIVE, 1'h1);
		RESET_N = 1'h0;
		@(negedge CLK_SYS);
		chk({DEST_WR.we, MEM_WR.we, PTR_UPD.we, PREFIX_ACTIVE}, 4'h0);
		RESET_N = 1'h1;
		one(7'h09, 16'h0034, 1'h1, mdd_pkg::TGT_SUM_REG, 1'h0);
		chk(DEST_WR.idx, 5'h00);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		#20000;
		fail_count++;
		tally_and_finish();
	end
	initial begin
		repeat (2) @(posedge CLK_SYS);
		@(negedge CLK_SYS);
		RESET_N = 1'h1;
		t_null();
		t_module();
		t_core();
		t_mem();
		t_regs();
		t_bank2();
		t_reset();
		tally_and_finish();
	end
endmodule
